/* File: logic/rsfm_pkg.sv */
// rsfm_pkg: register map, field positions, reset values and window counts of the
// resolver signal fault monitor.
// assumes: used by rsfm_monitor and rsfm_window_timer, referenced by package::name only.
package rsfm_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_LOSS_THR    = 8'h88;
  localparam logic [7:0] OFS_OVR_THR     = 8'h89;
  localparam logic [7:0] OFS_MISM_THR    = 8'h8a;
  localparam logic [7:0] OFS_MAX_INIT    = 8'h8b;
  localparam logic [7:0] OFS_MIN_INIT    = 8'h8c;
  localparam logic [7:0] OFS_CONTROL     = 8'h90;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'hff;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_PARITY    = 0;
  localparam int BIT_MISMATCH  = 1;
  localparam int BIT_OVERRANGE = 2;
  localparam int BIT_LOW_AMP   = 3;
  localparam int BIT_DISCONN   = 4;
  localparam int BIT_TRACKLOSS = 5;
  localparam int BIT_CLIPPING  = 7;
  localparam int BIT_CFG_MODE  = 0;
  localparam int BIT_BAND_LO   = 1;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_LOSS_THR = 8'h10;
  localparam logic [7:0] RST_OVR_THR  = 8'hf0;
  localparam logic [7:0] RST_MISM_THR = 8'h20;
  localparam logic [7:0] RST_MAX_INIT = 8'h00;
  localparam logic [7:0] RST_MIN_INIT = 8'hff;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // ---------------------------------------------------------------------------
  // window counter periods in internal clock cycles
  // ---------------------------------------------------------------------------
  localparam logic [10:0] WIN_LOW_BAND  = 11'd1065; // 2 to under 4 kHz
  localparam logic [10:0] WIN_MID_BAND  = 11'd554;  // 4 to under 8 kHz
  localparam logic [10:0] WIN_HIGH_BAND = 11'd256;  // 8 to 20 kHz
  localparam int          CLK_DIVIDE    = 2;

  typedef enum logic [1:0] {
    BAND_LOW  = 2'b00,
    BAND_MID  = 2'b01,
    BAND_HIGH = 2'b10
  } rsfm_band_type;

endpackage : rsfm_pkg

/* File: logic/rsfm_window_timer.sv */
// rsfm_window_timer: divides the input clock by two and counts window periods.
// assumes: clk is the input clock; band is stable or changes only between windows.
module rsfm_window_timer (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire rsfm_pkg::rsfm_band_type band,
  output logic                       tickEn,
  output logic                       windowEnd
);

  logic        divPhase_r;
  logic [10:0] winCount_r;
  logic [10:0] winLen;

  // ---------------------------------------------------------------------------
  // internal clock enable
  // ---------------------------------------------------------------------------
  // one enable every second input clock edge rather than a derived clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divPhase_r <= 1'b0;
    end else begin
      divPhase_r <= ~divPhase_r; // R13
    end
  end
  assign tickEn = divPhase_r;

  // ---------------------------------------------------------------------------
  // window counter
  // ---------------------------------------------------------------------------
  always_comb begin
    case (band)
      rsfm_pkg::BAND_LOW: winLen = rsfm_pkg::WIN_LOW_BAND; // R16
      rsfm_pkg::BAND_MID: winLen = rsfm_pkg::WIN_MID_BAND; // R16
      default:            winLen = rsfm_pkg::WIN_HIGH_BAND; // R16
    endcase
  end

  // every window spans at least half of the slowest excitation period in its band
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      winCount_r <= 11'h000;
    end else if (tickEn) begin
      if (winCount_r >= winLen - 11'd1) begin
        winCount_r <= 11'h000; // R17
      end else begin
        winCount_r <= winCount_r + 11'd1;
      end
    end
  end
  assign windowEnd = tickEn && (winCount_r >= winLen - 11'd1); // R15

endmodule : rsfm_window_timer

/* File: logic/rsfm_monitor.sv */
// rsfm_monitor: fault monitor of a resolver-to-digital converter, with its register port.
// assumes: demodulated sine, cosine and tracked-angle trig terms come from same-clock logic;
// pin status flags (disconnect, clipping) are asynchronous and are synchronised here.
//
// The address-and-strobe port was decided locally.

// ---------------------------------------------------------------------------
// Operation
// R1 - angle output moves one step per step
// R2 - low sine or cosine amplitude flags loss
// R3 - disconnected input pin flags signal loss
// R4 - clipping and parity error also flag loss
// R5 - loss drives both fault pins low, latched
// R6 - pins clear on configuration-mode fault read
// R7 - loss outranks degradation and tracking loss
// R8 - high sine or cosine amplitude flags degradation
// R9 - max minus min above mismatch flags degradation
// R10 - min/max trackers seeded from start registers
// R11 - degradation drives degradation pin low, latched
// R12 - degradation outranks tracking loss on pins
// R13 - internal clock is input clock halved
// R14 - monitor and min/max update on internal tick
// R15 - thresholds compared once per window end
// R16 - window is 1065, 554 or 256 cycles
// R17 - two windows span one excitation period
// R18 - amplitude fault reported within two windows
// R19 - persistent fault reappears within one window
// R20 - mismatch may need one full rotation
// R21 - tracking loss drives tracking pin only, unlatched
// R22 - clipping sets fault flag bit seven
// R23 - parity error sets fault flag bit zero
// R24 - after reset pins high, trackers restart
module rsfm_monitor #(
  parameter int AMP_W   = 8,
  parameter int ANGLE_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [7:0]              regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [7:0]              regRdata,
  input  wire logic signed [AMP_W-1:0] sineAmp,
  input  wire logic signed [AMP_W-1:0] cosineAmp,
  input  wire logic signed [AMP_W-1:0] sinPhi,
  input  wire logic signed [AMP_W-1:0] cosPhi,
  input  wire logic                    angleStepUp,
  input  wire logic                    angleStepDown,
  input  wire logic                    pinDisconnect,
  input  wire logic                    pinClipping,
  input  wire logic                    trackingLoss,
  output logic      [ANGLE_W-1:0]      angleOut,
  output logic                         degradationFaultN,
  output logic                         trackingFaultN
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [7:0]  lossThr_r;
  logic [7:0]  ovrThr_r;
  logic [7:0]  mismThr_r;
  logic [7:0]  maxInit_r;
  logic [7:0]  minInit_r;
  logic [7:0]  control_r;
  logic [7:0]  faultFlags_r;
  logic [7:0]  monMin_r;
  logic [7:0]  monMax_r;
  logic [7:0]  sinPeak_r;
  logic [7:0]  cosPeak_r;
  logic [7:0]  monitorMag_r;
  logic        lossLatch_r;
  logic        degrLatch_r;
  logic        trackLoss_r;
  logic [1:0]  discSync_r;
  logic [1:0]  clipSync_r;
  logic [1:0]  trackSync_r;
  logic        tickEn;
  logic        windowEnd;
  logic        faultRead;
  logic        reseed;
  logic        parityErr;
  logic        lowAmp;
  logic        overAmp;
  logic        mismatch;
  logic        lossNow;
  logic        degrNow;
  logic [7:0]  faultSet;
  logic [7:0]  magNow;
  logic [7:0]  sinMag;
  logic [7:0]  cosMag;
  logic [7:0]  rdMux;
  logic signed [2*AMP_W:0] monProd;
  rsfm_pkg::rsfm_band_type band;

  // magnitude of a signed amplitude, truncated to its top 8 bits
  function automatic logic [7:0] mag8(input logic signed [AMP_W-1:0] v);
    logic [AMP_W-1:0] a;
    a = v[AMP_W-1] ? AMP_W'(-v) : AMP_W'(v);
    mag8 = a[AMP_W-1:AMP_W-8];
  endfunction : mag8

  // even parity over all eight bits; an odd count of ones is an error
  function automatic logic parityBad(input logic [7:0] r);
    parityBad = ^r;
  endfunction : parityBad

  // ---------------------------------------------------------------------------
  // window timer and band select
  // ---------------------------------------------------------------------------
  assign band = control_r[rsfm_pkg::BIT_BAND_LO+1] ? rsfm_pkg::BAND_HIGH :
                control_r[rsfm_pkg::BIT_BAND_LO]   ? rsfm_pkg::BAND_MID  :
                                                     rsfm_pkg::BAND_LOW;

  rsfm_window_timer u_timer (
    .clk       (clk),
    .resetn    (resetn),
    .band      (band),
    .tickEn    (tickEn),
    .windowEnd (windowEnd)
  );

  // ---------------------------------------------------------------------------
  // pin status synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      discSync_r  <= 2'b00;
      clipSync_r  <= 2'b00;
      trackSync_r <= 2'b00;
    end else begin
      discSync_r  <= {discSync_r[0], pinDisconnect};
      clipSync_r  <= {clipSync_r[0], pinClipping};
      trackSync_r <= {trackSync_r[0], trackingLoss};
    end
  end

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  // configuration registers are written in any mode; only the fault read needs config mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lossThr_r <= rsfm_pkg::RST_LOSS_THR;
      ovrThr_r  <= rsfm_pkg::RST_OVR_THR;
      mismThr_r <= rsfm_pkg::RST_MISM_THR;
      maxInit_r <= rsfm_pkg::RST_MAX_INIT;
      minInit_r <= rsfm_pkg::RST_MIN_INIT;
      control_r <= rsfm_pkg::RST_CONTROL;
    end else if (regWrite) begin
      case (regAddr)
        rsfm_pkg::OFS_LOSS_THR: lossThr_r <= regWdata;
        rsfm_pkg::OFS_OVR_THR:  ovrThr_r  <= regWdata;
        rsfm_pkg::OFS_MISM_THR: mismThr_r <= regWdata;
        rsfm_pkg::OFS_MAX_INIT: maxInit_r <= regWdata;
        rsfm_pkg::OFS_MIN_INIT: minInit_r <= regWdata;
        rsfm_pkg::OFS_CONTROL:  control_r <= regWdata;
        default:                ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------------
  always_comb begin
    case (regAddr)
      rsfm_pkg::OFS_LOSS_THR:    rdMux = lossThr_r;
      rsfm_pkg::OFS_OVR_THR:     rdMux = ovrThr_r;
      rsfm_pkg::OFS_MISM_THR:    rdMux = mismThr_r;
      rsfm_pkg::OFS_MAX_INIT:    rdMux = maxInit_r;
      rsfm_pkg::OFS_MIN_INIT:    rdMux = minInit_r;
      rsfm_pkg::OFS_CONTROL:     rdMux = control_r;
      rsfm_pkg::OFS_FAULT_FLAGS: rdMux = faultFlags_r;
      default:                   rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRead ? rdMux : 8'h00;
    end
  end

  assign faultRead = regRead && (regAddr == rsfm_pkg::OFS_FAULT_FLAGS)
                     && control_r[rsfm_pkg::BIT_CFG_MODE]; // R6

  // ---------------------------------------------------------------------------
  // monitor signal and min/max trackers
  // ---------------------------------------------------------------------------
  // monitor = sin(theta)*sin(phi) + cos(theta)*cos(phi), scaled back to amplitude width
  assign monProd = (2*AMP_W+1)'(sineAmp * sinPhi) + (2*AMP_W+1)'(cosineAmp * cosPhi);
  assign magNow  = mag8(AMP_W'(monProd >>> (AMP_W-1)));
  assign sinMag  = mag8(sineAmp);
  assign cosMag  = mag8(cosineAmp);

  // trackers restart from the user start values after each compare only; reseeding on a
  // clear would let a window end just after it judge empty peaks as a lost signal
  assign reseed = windowEnd;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitorMag_r <= 8'h00;
      monMin_r     <= rsfm_pkg::RST_MIN_INIT;
      monMax_r     <= rsfm_pkg::RST_MAX_INIT;
      sinPeak_r    <= 8'h00;
      cosPeak_r    <= 8'h00;
    end else if (reseed) begin
      monitorMag_r <= magNow;
      monMin_r     <= minInit_r; // R10 R24
      monMax_r     <= maxInit_r; // R10 R24
      sinPeak_r    <= 8'h00;
      cosPeak_r    <= 8'h00;
    end else if (tickEn) begin
      monitorMag_r <= magNow; // R14
      if (magNow < monMin_r) begin
        monMin_r <= magNow; // R14
      end
      if (magNow > monMax_r) begin
        monMax_r <= magNow; // R14
      end
      if (sinMag > sinPeak_r) begin
        sinPeak_r <= sinMag;
      end
      if (cosMag > cosPeak_r) begin
        cosPeak_r <= cosMag;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // window-end compares
  // ---------------------------------------------------------------------------
  // peaks over a window that holds an excitation crest, so a fault shows in two windows
  assign lowAmp    = (sinPeak_r < lossThr_r) || (cosPeak_r < lossThr_r); // R2 R18
  assign overAmp   = (sinPeak_r > ovrThr_r) || (cosPeak_r > ovrThr_r); // R8 R18
  // mismatch swings at twice shaft rate, so a slow shaft needs up to a turn: R20
  assign mismatch  = (monMax_r > monMin_r) && ((monMax_r - monMin_r) > mismThr_r); // R9
  assign parityErr = parityBad(lossThr_r) || parityBad(ovrThr_r) || parityBad(mismThr_r)
                     || parityBad(maxInit_r) || parityBad(minInit_r);
  assign lossNow   = (windowEnd && lowAmp) || discSync_r[1] || clipSync_r[1]
                     || parityErr; // R3 R4
  assign degrNow   = windowEnd && (overAmp || mismatch);

  always_comb begin
    faultSet = 8'h00;
    faultSet[rsfm_pkg::BIT_PARITY]    = parityErr; // R23
    faultSet[rsfm_pkg::BIT_MISMATCH]  = windowEnd && mismatch;
    faultSet[rsfm_pkg::BIT_OVERRANGE] = windowEnd && overAmp;
    faultSet[rsfm_pkg::BIT_LOW_AMP]   = windowEnd && lowAmp;
    faultSet[rsfm_pkg::BIT_DISCONN]   = discSync_r[1];
    faultSet[rsfm_pkg::BIT_TRACKLOSS] = trackSync_r[1];
    faultSet[rsfm_pkg::BIT_CLIPPING]  = clipSync_r[1]; // R22
  end

  // ---------------------------------------------------------------------------
  // latched fault state
  // ---------------------------------------------------------------------------
  // a fault seen in the clearing cycle survives: set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      faultFlags_r <= 8'h00;
      lossLatch_r  <= 1'b0;
      degrLatch_r  <= 1'b0;
      trackLoss_r  <= 1'b0;
    end else begin
      faultFlags_r <= (faultRead ? 8'h00 : faultFlags_r) | faultSet; // R6 R19
      lossLatch_r  <= (lossLatch_r && !faultRead) || lossNow; // R5 R6
      degrLatch_r  <= (degrLatch_r && !faultRead) || degrNow; // R11 R6
      trackLoss_r  <= trackSync_r[1]; // R21
    end
  end

  // ---------------------------------------------------------------------------
  // fault pins
  // ---------------------------------------------------------------------------
  // priority: loss, then degradation, then tracking loss; one pin pair per state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      degradationFaultN <= 1'b1; // R24
      trackingFaultN    <= 1'b1; // R24
    end else if (lossLatch_r) begin
      degradationFaultN <= 1'b0; // R5 R7
      trackingFaultN    <= 1'b0; // R5 R7
    end else if (degrLatch_r) begin
      degradationFaultN <= 1'b0; // R11
      trackingFaultN    <= 1'b1; // R12
    end else begin
      degradationFaultN <= 1'b1;
      trackingFaultN    <= !trackLoss_r; // R21
    end
  end

  // ---------------------------------------------------------------------------
  // angle output
  // ---------------------------------------------------------------------------
  // the tracking loop issues step pulses; one step moves the code by exactly one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      angleOut <= '0;
    end else if (angleStepUp && !angleStepDown) begin
      angleOut <= angleOut + ANGLE_W'(1); // R1
    end else if (angleStepDown && !angleStepUp) begin
      angleOut <= angleOut - ANGLE_W'(1); // R1
    end
  end

endmodule : rsfm_monitor

/* File: bench/rsfm_resolver_model.sv */
// rsfm_resolver_model: resolver and tracking loop as seen through demodulated trig terms.
// assumes: converter tracks at 45 degrees; mode 0 healthy, 1 weak, 2 strong, 3 mismatched.
module rsfm_resolver_model (
  input  wire logic        clk,
  input  wire logic [1:0]  mode,
  output logic signed [7:0] sineAmp,
  output logic signed [7:0] cosineAmp,
  output logic signed [7:0] sinPhi,
  output logic signed [7:0] cosPhi
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] phase_r = 4'h0;

  // free-running phase; period 8 so both internal tick phases see each level
  always_ff @(posedge clk) begin
    phase_r <= phase_r + 4'h1;
  end

  // tracked angle at 45 degrees: sin and cos of it are equal, monitor stays flat
  assign sinPhi    = 8'sh5a;
  assign cosPhi    = 8'sh5a;
  assign sineAmp   = (mode == 2'h1) ? 8'sh0a : (mode == 2'h2) ? 8'sh64 : 8'sh3c;
  // mismatch: cosine peak stays healthy, but the monitor swings with it
  assign cosineAmp = (mode == 2'h3 && phase_r[2]) ? 8'sh00 : sineAmp;
endmodule : rsfm_resolver_model

/* File: bench/rsfm_monitor_sva.sv */
// rsfm_monitor_sva: port-level checks of the fault monitor and its register port.
// assumes: bound to rsfm_monitor; single clock domain, async active-low reset.
module rsfm_monitor_sva #(
  parameter int AMP_W   = 8,
  parameter int ANGLE_W = 16
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [7:0]         regAddr,
  input wire logic [7:0]         regWdata,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [7:0]         regRdata,
  input wire logic               angleStepUp,
  input wire logic               angleStepDown,
  input wire logic               pinClipping,
  input wire logic               trackingLoss,
  input wire logic [ANGLE_W-1:0] angleOut,
  input wire logic               degradationFaultN,
  input wire logic               trackingFaultN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic faultRead;
  logic mapped;

  // fault register read; only this may release the latched pins
  assign faultRead = regRead && (regAddr == rsfm_pkg::OFS_FAULT_FLAGS);
  assign mapped    = regAddr inside {[8'h88:8'h8c], 8'h90, 8'hff};

  // ---------------------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  chk_unmapped_zero: assert property (($past(regRead) && !$past(mapped)) |-> regRdata == 8'h00)
    else $error("unmapped read returned data");
  chk_reg_readback: assert property ((regWrite && regAddr == 8'h88) ##2
    (regRead && regAddr == 8'h88) |=> regRdata == $past(regWdata, 3))
    else $error("threshold readback differs from written value");

  // ---------------------------------------------------------------------------
  // fault pins and angle output
  // ---------------------------------------------------------------------------
  chk_pins_reset: assert property ($rose(resetn) |-> degradationFaultN && trackingFaultN)
    else $error("fault pins low after reset");
  chk_clip_both: assert property ($rose(pinClipping) |->
    ##[1:5] (!degradationFaultN && !trackingFaultN))
    else $error("clipping did not pull both pins low");
  chk_fault_held: assert property ((!degradationFaultN && !faultRead && !$past(faultRead))
    |=> !degradationFaultN)
    else $error("latched fault released without fault read");
  chk_track_cause: assert property ((!trackingFaultN && degradationFaultN) |->
    ($past(trackingLoss, 2) || $past(trackingLoss, 3) || $past(trackingLoss, 4)))
    else $error("tracking pin low without tracking loss");
  chk_track_release: assert property (((!trackingLoss) [*6]) ##0 degradationFaultN
    |-> trackingFaultN)
    else $error("tracking pin stayed low after tracking loss ended");
  chk_angle_step: assert property (($past(angleStepUp) && !$past(angleStepDown)) |->
    angleOut == $past(angleOut) + 1'b1)
    else $error("angle output did not advance by one step");

  cover property (faultRead ##1 regRdata[rsfm_pkg::BIT_CLIPPING]);
  cover property (!trackingFaultN && degradationFaultN);
  cover property ($fell(degradationFaultN));
endmodule : rsfm_monitor_sva

bind rsfm_monitor rsfm_monitor_sva #(
  .AMP_W   (AMP_W),
  .ANGLE_W (ANGLE_W)
) rsfm_monitor_sva_i (
  .clk (clk), .resetn (resetn), .regAddr (regAddr), .regWdata (regWdata),
  .regWrite (regWrite), .regRead (regRead), .regRdata (regRdata),
  .angleStepUp (angleStepUp), .angleStepDown (angleStepDown),
  .pinClipping (pinClipping), .trackingLoss (trackingLoss), .angleOut (angleOut),
  .degradationFaultN (degradationFaultN), .trackingFaultN (trackingFaultN)
);

/* File: bench/tb_top.sv */
// tb_top: register-level tests of the resolver signal fault monitor.
// assumes: 20 MHz clock; high excitation band, so a window is 512 input clocks.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int WIN = 2 * rsfm_pkg::WIN_HIGH_BAND; // halved internal clock
  localparam int FLT = 2 * WIN + 8;                  // two windows plus pin latency

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdata;
  logic signed [7:0] sineAmp, cosineAmp, sinPhi, cosPhi;
  logic        angleStepUp = 1'b0;
  logic        angleStepDown = 1'b0;
  logic        pinDisconnect = 1'b0;
  logic        pinClipping = 1'b0;
  logic        trackingLoss = 1'b0;
  logic [15:0] angleOut;
  logic        degradationFaultN, trackingFaultN;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  rdv;
  int          fails = 0;
  int          numChecks = 0;
  logic [7:0]  ofs [6] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h90};
  logic [7:0]  rst [6] = '{8'h10, 8'hf0, 8'h20, 8'h00, 8'hff, 8'h00};
  // even-parity settings; config mode on, high band
  logic [7:0]  cfg [6] = '{8'h11, 8'h50, 8'h21, 8'h00, 8'hff, 8'h05};
  int          ampBit [3] = '{rsfm_pkg::BIT_LOW_AMP, rsfm_pkg::BIT_OVERRANGE,
                              rsfm_pkg::BIT_MISMATCH};

  always #25 clk = ~clk;

  rsfm_monitor rsfm_monitor_i (
    .clk (clk), .resetn (resetn), .regAddr (regAddr), .regWdata (regWdata),
    .regWrite (regWrite), .regRead (regRead), .regRdata (regRdata),
    .sineAmp (sineAmp), .cosineAmp (cosineAmp), .sinPhi (sinPhi), .cosPhi (cosPhi),
    .angleStepUp (angleStepUp), .angleStepDown (angleStepDown),
    .pinDisconnect (pinDisconnect), .pinClipping (pinClipping),
    .trackingLoss (trackingLoss), .angleOut (angleOut),
    .degradationFaultN (degradationFaultN), .trackingFaultN (trackingFaultN)
  );

  rsfm_resolver_model rsfm_resolver_model_i (
    .clk (clk), .mode (mode), .sineAmp (sineAmp), .cosineAmp (cosineAmp),
    .sinPhi (sinPhi), .cosPhi (cosPhi)
  );

  // ---------------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // bounded wait for a pin pattern, then compare it
  task automatic wait_pins(input logic dExp, input logic tExp, input int lim);
    int n;
    n = 0;
    while ((degradationFaultN !== dExp || trackingFaultN !== tExp) && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    check({degradationFaultN, trackingFaultN}, {dExp, tExp});
  endtask : wait_pins

  // healthy inputs for two windows, clear, then demand a clean flag read
  task automatic settle();
    @(posedge clk);
    mode <= 2'h0;
    repeat (FLT) @(posedge clk);
    rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
    repeat (FLT) @(posedge clk);
    rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
    check(rdv, 8'h00);
    wait_pins(1'b1, 1'b1, 4);
  endtask : settle

  task automatic tally_and_finish();
    if (fails == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 check({degradationFaultN, trackingFaultN}, 2'b11);
    @(posedge clk);
    angleStepUp <= 1'b1;
    repeat (3) @(posedge clk);
    angleStepUp   <= 1'b0;
    angleStepDown <= 1'b1;
    @(posedge clk);
    angleStepDown <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(angleOut, 16'h0002);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], rdv);
      check(rdv, rst[i]);
    end
    rd(8'h55, rdv);
    check(rdv, 8'h00);
    // odd-parity reset contents must already be flagged
    rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
    check(rdv[rsfm_pkg::BIT_PARITY], 1'b1);
    wait_pins(1'b0, 1'b0, 4);
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], cfg[i]);
      rd(ofs[i], rdv);
      check(rdv, cfg[i]);
    end
    settle();
    // weak, strong and mismatched inputs; each must persist after a clear
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      wait_pins(1'b0, m != 1, FLT);
      rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
      check(rdv[ampBit[m-1]], 1'b1);
      repeat (2) @(posedge clk);
      #1 check({degradationFaultN, trackingFaultN}, 2'b11);
      wait_pins(1'b0, m != 1, WIN + 8);
      settle();
    end
    // clipping then disconnect: latched beyond the cause, config mode needed to clear
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pinClipping   <= (i == 0);
      pinDisconnect <= (i == 1);
      wait_pins(1'b0, 1'b0, 6);
      repeat (10) @(posedge clk);
      pinClipping   <= 1'b0;
      pinDisconnect <= 1'b0;
      wr(rsfm_pkg::OFS_CONTROL, 8'h06);
      rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
      repeat (20) @(posedge clk);
      #1 check({degradationFaultN, trackingFaultN}, 2'b00);
      wr(rsfm_pkg::OFS_CONTROL, 8'h05);
      rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
      check(rdv[(i == 0) ? rsfm_pkg::BIT_CLIPPING : rsfm_pkg::BIT_DISCONN], 1'b1);
      settle();
    end
    // tracking loss alone, then under degradation, then under signal loss
    @(posedge clk);
    trackingLoss <= 1'b1;
    wait_pins(1'b1, 1'b0, 6);
    rd(rsfm_pkg::OFS_FAULT_FLAGS, rdv);
    check(rdv[rsfm_pkg::BIT_TRACKLOSS], 1'b1);
    @(posedge clk);
    trackingLoss <= 1'b0;
    wait_pins(1'b1, 1'b1, 6);
    @(posedge clk);
    trackingLoss <= 1'b1;
    mode         <= 2'h2;
    wait_pins(1'b0, 1'b1, FLT);
    @(posedge clk);
    pinClipping <= 1'b1;
    wait_pins(1'b0, 1'b0, 6);
    @(posedge clk);
    pinClipping  <= 1'b0;
    trackingLoss <= 1'b0;
    settle();
    tally_and_finish();
  end

  // watchdog: the sequence needs about 19000 clocks
  initial begin
    #(60000 * 50);
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
